// file: dv/biop_board.sv
// board model: external circuitry on the eight port pins
`default_nettype none
module biop_board (
    input  wire logic       clock,
    input  wire logic [7:0] pins_out,
    input  wire logic [7:0] pins_oe,
    input  wire logic [7:0] pullup_on,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic [7:0]      pins_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_r = 8'h00;
    // free-running toggle keeps a floating level known even before reset
    always_ff @(posedge clock)
    begin
        last_r <= ~last_r;
    end
    // a floating pin flips each cycle so a stale level never passes for a driven one
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            pins_in[i] = pins_oe[i] ? pins_out[i] : ext_en[i] ? ext_val[i]
                       : pullup_on[i] ? 1'b1 : last_r[i];
        end
    end
endmodule : biop_board
`default_nettype wire

// file: dv/biop_port_tb.sv
// testbench: register bus, pin direction, pull-ups, streaming and pwm override
`default_nettype none
module bidir_octal_io_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = biop_pkg::HSIZE_WORD;
    logic        hreadyout, hresp, ttl_thresholds, serial_disable;
    logic [7:0]  pins_in, pins_out, pins_oe, pullup_on, stream_rx_data;
    logic [7:0]  ext_en = 8'h00, ext_val = 8'h00;
    logic [3:0]  neighbor_pins_in = 4'h9;
    biop_pkg::biop_stream_t stream_in = '0;
    biop_pkg::biop_pwm_t pwm_in = '0;
    int err_total = 0, tests_run = 0;
    always #2.5 clock = ~clock;
    biop_port dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_pins_in(pins_in),
        .port_pins_out(pins_out), .port_pins_oe(pins_oe), .pullup_on(pullup_on),
        .ttl_thresholds(ttl_thresholds), .stream_in(stream_in),
        .stream_rx_data(stream_rx_data),
        .pwm_in(pwm_in), .neighbor_pins_in(neighbor_pins_in),
        .serial_disable(serial_disable));
    biop_board board (.clock(clock), .pins_out(pins_out), .pins_oe(pins_oe),
        .pullup_on(pullup_on), .ext_en(ext_en), .ext_val(ext_val), .pins_in(pins_in));
    // ----------------------------------------
    // bus tasks and checks
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= wr;
        htrans <= biop_pkg::HTRANS_NONSEQ;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic settle();
        repeat (4) @(posedge clock);
    endtask : settle
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk({24'h0, pullup_on}, 32'h0);
        chk({24'h0, pins_oe}, 32'h0);
        chk({31'h0, ttl_thresholds}, 32'h0);
        chk({24'h0, stream_rx_data}, 32'h0);
        chk({30'h0, hresp, hreadyout}, 32'h1);
        bus(1'b0, biop_pkg::ADDR_DIR, 32'h0);
        chk(rd, 32'hFF);
        bus(1'b0, biop_pkg::ADDR_NEIGHBOR, 32'h0);
        chk(rd, 32'h09);
        $display("reset test done");
    endtask : t_reset
    task automatic t_dir();
        ext_en <= 8'h0F;
        ext_val <= 8'h03;
        bus(1'b1, biop_pkg::ADDR_LATCH, 32'hA5);
        bus(1'b1, biop_pkg::ADDR_DIR, 32'h0F);
        settle();
        chk({24'h0, pins_oe}, 32'hF0);
        chk({24'h0, pins_out & pins_oe}, 32'hA0);
        bus(1'b0, biop_pkg::ADDR_LATCH, 32'h0);
        chk(rd, 32'hA5);
        bus(1'b0, biop_pkg::ADDR_PIN_LEVEL, 32'h0);
        chk(rd, 32'hA3);
        bus(1'b1, biop_pkg::ADDR_PIN_LEVEL, 32'h3C);
        bus(1'b0, biop_pkg::ADDR_LATCH, 32'h0);
        chk(rd, 32'h3C);
        $display("direction test done");
    endtask : t_dir
    task automatic t_pull();
        bus(1'b1, biop_pkg::ADDR_NEIGHBOR, 32'h80);
        settle();
        chk({24'h0, pullup_on}, 32'h0C);
        bus(1'b0, biop_pkg::ADDR_NEIGHBOR, 32'h0);
        chk(rd, 32'h89);
        $display("pull-up test done");
    endtask : t_pull
    task automatic t_stream();
        ext_en <= 8'h00;
        stream_in <= '{enable: 1'b1, out_data: 8'h5A, out_en: 8'hFF};
        settle();
        chk({24'h0, pins_out}, 32'h5A);
        chk({24'h0, stream_rx_data}, 32'h5A);
        chk({31'h0, ttl_thresholds}, 32'h1);
        chk({24'h0, pullup_on}, 32'h0);
        $display("streaming test done");
    endtask : t_stream
    task automatic t_pwm();
        stream_in <= '0;
        pwm_in <= '{multi_out: 1'b1, chan: 3'b101, shutdown: 1'b0};
        bus(1'b1, biop_pkg::ADDR_DIR, 32'hFF);
        settle();
        chk({24'h0, pins_oe}, 32'h00);
        stream_in <= '{enable: 1'b1, out_data: 8'h5A, out_en: 8'hFF};
        bus(1'b1, biop_pkg::ADDR_DIR, 32'h1F);
        settle();
        chk({24'h0, pins_out}, 32'hBA);
        chk({31'h0, serial_disable}, 32'h1);
        bus(1'b1, biop_pkg::ADDR_MUX_CTRL, 32'h1);
        pwm_in <= '{multi_out: 1'b1, chan: 3'b101, shutdown: 1'b1};
        settle();
        chk({24'h0, pins_oe}, 32'h1F);
        bus(1'b0, biop_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h7);
        $display("pwm test done");
    endtask : t_pwm
    initial
    begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_dir();
        t_pull();
        t_stream();
        t_pwm();
        end_of_test();
    end
    // the whole sequence needs well under a thousand cycles
    initial
    begin
        #20000;
        err_total++;
        end_of_test();
    end
endmodule : bidir_octal_io_port_tb
`default_nettype wire

// file: rtl/biop_port.sv
// bidirectional octal i/o port with register file on ahb-lite
// Contract
// - direction bit 1 puts the pin driver in high impedance; with streaming enabled, out_en drives the pin regardless of direction
// - direction bit 0 drives the latch bit onto the pin
// - latch register is mapped; reads return latch, not pin levels
// - eight pins, each direction set independently
// - schmitt thresholds normally, ttl thresholds in streaming mode
// - one pull-up per pin, all enabled by bit 7 of neighbour register
// - pull-up off when pin is output or owned by a peripheral
// - reset clears the pull-up enable
// - reset leaves pwm-shared pins as digital inputs
// - streaming port data overrides latch; pins feed its input
// - pwm b,c,d drive pins 5,6,7 over latch and streaming data
// - pwm pins may tri-state on shutdown when configured
// - dual or quad pwm disables serial module functions here
// - with pull-up enable set, pull-up active only where latch bit set
//
// The AHB-Lite register port and the address map are this design's own decisions.
`default_nettype none
module biop_port #(
    parameter int unsigned           W = biop_pkg::WIDTH
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic [W-1:0]        port_pins_in,
    output logic [W-1:0]             port_pins_out,
    output logic [W-1:0]             port_pins_oe,
    output logic [W-1:0]             pullup_on,
    output logic                     ttl_thresholds,
    input  wire biop_pkg::biop_stream_t stream_in,
    output logic [W-1:0]                stream_rx_data,
    input  wire biop_pkg::biop_pwm_t pwm_in,
    input  wire logic [3:0]          neighbor_pins_in,
    output logic                     serial_disable
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [W-1:0]  latch_r;
    logic [W-1:0]  dir_r;
    logic          pullup_en_r;
    logic [7:0]    mux_r;
    logic [W-1:0]  pins_r;
    logic [3:0]    neigh_pins_r;
    logic          wr_pend_r;
    logic [11:0]   addr_r;
    logic [W-1:0]  pin_out_nxt;
    logic [W-1:0]  pin_oe_nxt;
    logic [W-1:0]  owned;
    logic          acc;
    logic          wr_latch;
    logic [W-1:0]  pwm_lvl;

    function automatic logic [31:0] read_mux(input logic [11:0] a);
        case (a)
            biop_pkg::ADDR_PIN_LEVEL: read_mux = 32'(pins_r);
            biop_pkg::ADDR_LATCH:     read_mux = 32'(latch_r);
            biop_pkg::ADDR_DIR:       read_mux = 32'(dir_r);
            biop_pkg::ADDR_NEIGHBOR:  read_mux = {24'h000000, pullup_en_r, 3'h0, neigh_pins_r};
            biop_pkg::ADDR_MUX_CTRL:  read_mux = {24'h000000, mux_r};
            biop_pkg::ADDR_STATUS:    read_mux = {29'h0000000, pwm_in.multi_out,
                                                  stream_in.enable, pwm_in.shutdown};
            default:                  read_mux = 32'h00000000;
        endcase
    endfunction : read_mux

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // zero wait states: write data lands one edge after the address phase
    assign acc = hsel && hready && (htrans == biop_pkg::HTRANS_NONSEQ);

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wr_pend_r <= 1'b0;
            addr_r    <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            wr_pend_r <= acc && hwrite;
            if (acc)
                addr_r <= haddr[11:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // hrdata registered at address phase so it stands through the data phase
    // a read right behind a write to the same register still sees the old value
    always_ff @(posedge clock)
    begin
        if (rst)
            hrdata <= 32'h00000000;
        else if (acc && !hwrite)
            hrdata <= read_mux(haddr[11:0]);
    end

    // pin-level and latch writes both land in the latch
    assign wr_latch = wr_pend_r && (addr_r == biop_pkg::ADDR_LATCH ||
                                    addr_r == biop_pkg::ADDR_PIN_LEVEL);

    always_ff @(posedge clock)
    begin
        if (rst)
            latch_r <= biop_pkg::LATCH_RST;
        else if (wr_latch)
            latch_r <= hwdata[W-1:0];
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            dir_r <= biop_pkg::DIR_RST;
        else if (wr_pend_r && addr_r == biop_pkg::ADDR_DIR)
            dir_r <= hwdata[W-1:0];
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            pullup_en_r <= biop_pkg::NEIGH_RST[biop_pkg::PULLUP_BIT];
        else if (wr_pend_r && addr_r == biop_pkg::ADDR_NEIGHBOR)
            pullup_en_r <= hwdata[biop_pkg::PULLUP_BIT];
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            mux_r <= biop_pkg::MUX_RST;
        else if (wr_pend_r && addr_r == biop_pkg::ADDR_MUX_CTRL)
            mux_r <= hwdata[7:0];
    end

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pins_r         <= '0;
            neigh_pins_r   <= 4'h0;
            stream_rx_data <= '0;
        end
        else
        begin
            pins_r         <= port_pins_in;
            neigh_pins_r   <= neighbor_pins_in;
            stream_rx_data <= stream_in.enable ? port_pins_in : '0;
        end
    end

    // ------------------------------------------------------------
    // output steering, priority pwm > streaming > latch
    // ------------------------------------------------------------
    // channel levels lifted onto the upper pins so no index runs below zero
    assign pwm_lvl = W'(pwm_in.chan) << biop_pkg::PWM_PIN_LO;

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_pin
            always_comb
            begin
                owned[g]       = 1'b0;
                pin_out_nxt[g] = latch_r[g];
                pin_oe_nxt[g]  = !dir_r[g];
                if (stream_in.enable)
                begin
                    owned[g]       = 1'b1;
                    pin_out_nxt[g] = stream_in.out_data[g];
                    pin_oe_nxt[g]  = stream_in.out_en[g];
                end
                // pwm pins honour direction so reset leaves them inputs
                if (g >= biop_pkg::PWM_PIN_LO && pwm_in.multi_out && !dir_r[g])
                begin
                    owned[g]       = 1'b1;
                    pin_out_nxt[g] = pwm_lvl[g];
                    pin_oe_nxt[g]  = !(pwm_in.shutdown && mux_r[biop_pkg::MUX_PWM_TRI]);
                end
            end
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            port_pins_out  <= '0;
            port_pins_oe   <= '0;
            pullup_on      <= '0;
            ttl_thresholds <= 1'b0;
            serial_disable <= 1'b0;
        end
        else
        begin
            port_pins_out  <= pin_out_nxt;
            port_pins_oe   <= pin_oe_nxt;
            // pull-up only on undriven, unowned pins whose latch is set
            pullup_on      <= {W{pullup_en_r}} & latch_r & dir_r & ~owned;
            ttl_thresholds <= stream_in.enable;
            serial_disable <= pwm_in.multi_out;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_latch_write;
        acc && hwrite && haddr[11:0] == biop_pkg::ADDR_LATCH;
    endsequence
    sequence s_pin_write;
        acc && hwrite && haddr[11:0] == biop_pkg::ADDR_PIN_LEVEL;
    endsequence
    sequence s_dir_write;
        acc && hwrite && haddr[11:0] == biop_pkg::ADDR_DIR;
    endsequence
    sequence s_latch_read;
        acc && !hwrite && haddr[11:0] == biop_pkg::ADDR_LATCH;
    endsequence
    sequence s_pin_read;
        acc && !hwrite && haddr[11:0] == biop_pkg::ADDR_PIN_LEVEL;
    endsequence

    chk_bus_okay: assert property (@(posedge clock) disable iff (rst)
        hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    chk_read_latch: assert property (@(posedge clock) disable iff (rst)
        s_latch_read |=> hrdata == 32'($past(latch_r)))
        else $error("latch read does not return latch");
    chk_pin_read: assert property (@(posedge clock) disable iff (rst)
        s_pin_read |=> hrdata == 32'($past(pins_r)))
        else $error("pin-level read does not return pins");
    chk_dir_write: assert property (@(posedge clock) disable iff (rst)
        s_dir_write ##1 1'b1 |=> dir_r == $past(hwdata[W-1:0]))
        else $error("direction write lost");

    chk_input_tristate: assert property (@(posedge clock) disable iff (rst)
        (dir_r[0] && !stream_in.enable) |=> !port_pins_oe[0])
        else $error("input pin driven");
    chk_output_latch: assert property (@(posedge clock) disable iff (rst)
        (!dir_r[0] && !stream_in.enable) |=> (port_pins_oe[0] && port_pins_out[0] == $past(latch_r[0])))
        else $error("output pin does not follow latch");
    chk_latch_update: assert property (@(posedge clock) disable iff (rst)
        s_latch_write ##1 1'b1 |=> latch_r == $past(hwdata[W-1:0]))
        else $error("latch write lost");
    chk_pin_write: assert property (@(posedge clock) disable iff (rst)
        s_pin_write ##1 1'b1 |=> latch_r == $past(hwdata[W-1:0]))
        else $error("pin-level write missed latch");
    chk_ttl_mode: assert property (@(posedge clock) disable iff (rst)
        ttl_thresholds == $past(stream_in.enable))
        else $error("threshold mode wrong");

    chk_pullup_gate: assert property (@(posedge clock) disable iff (rst)
        !pullup_en_r |=> pullup_on == '0)
        else $error("pull-up on while disabled");
    chk_pullup_latch: assert property (@(posedge clock) disable iff (rst)
        (pullup_en_r && latch_r[3] && dir_r[3] && !stream_in.enable) |=> pullup_on[3])
        else $error("pull-up missing on set latch bit");
    chk_pullup_output: assert property (@(posedge clock) disable iff (rst)
        !dir_r[3] |=> !pullup_on[3])
        else $error("pull-up on driven pin");
    chk_pullup_owned: assert property (@(posedge clock) disable iff (rst)
        stream_in.enable |=> pullup_on == '0)
        else $error("pull-up on pin owned by streaming port");

    chk_pwm_priority: assert property (@(posedge clock) disable iff (rst)
        (pwm_in.multi_out && !dir_r[7] && !pwm_in.shutdown)
        |=> port_pins_out[7] == $past(pwm_in.chan[2]) && port_pins_oe[7])
        else $error("pwm channel d not on pin 7");
    chk_pwm_shutdown: assert property (@(posedge clock) disable iff (rst)
        (pwm_in.multi_out && !dir_r[5] && pwm_in.shutdown && mux_r[0]) |=> !port_pins_oe[5])
        else $error("pwm pin not tri-stated");
    chk_pwm_input: assert property (@(posedge clock) disable iff (rst)
        (pwm_in.multi_out && dir_r[6] && !stream_in.enable) |=> !port_pins_oe[6])
        else $error("pwm drives a pin set as input");
    chk_stream_override: assert property (@(posedge clock) disable iff (rst)
        (stream_in.enable && !pwm_in.multi_out) |=> port_pins_out[2] == $past(stream_in.out_data[2]))
        else $error("streaming data not on pin");
    chk_stream_capture: assert property (@(posedge clock) disable iff (rst)
        stream_in.enable |=> stream_rx_data == $past(port_pins_in))
        else $error("streaming input not fed from pins");
    chk_stream_idle: assert property (@(posedge clock) disable iff (rst)
        !stream_in.enable |=> stream_rx_data == '0)
        else $error("streaming input active while disabled");

    chk_serial_off: assert property (@(posedge clock) disable iff (rst)
        pwm_in.multi_out |=> serial_disable)
        else $error("serial not disabled");
    chk_serial_idle: assert property (@(posedge clock) disable iff (rst)
        !pwm_in.multi_out |=> !serial_disable)
        else $error("serial disabled without multi-output pwm");
    chk_reset_state: assert property (@(posedge clock)
        $fell(rst) |-> !pullup_en_r && dir_r == biop_pkg::DIR_RST)
        else $error("reset state wrong");
endmodule : biop_port
`default_nettype wire

// file: shared/biop_pkg.sv
// package: register map, field positions and carriers for the octal i/o port
`default_nettype none
package biop_pkg;
    localparam int unsigned         WIDTH          = 8;
    localparam logic [11:0]         ADDR_PIN_LEVEL = 12'h000;
    localparam logic [11:0]         ADDR_LATCH     = 12'h004;
    localparam logic [11:0]         ADDR_DIR       = 12'h008;
    localparam logic [11:0]         ADDR_NEIGHBOR  = 12'h00C;
    localparam logic [11:0]         ADDR_MUX_CTRL  = 12'h010;
    localparam logic [11:0]         ADDR_STATUS    = 12'h014;
    localparam int unsigned         PULLUP_BIT     = 7;
    localparam int unsigned         NEIGH_DATA_W   = 4;
    localparam int unsigned         MUX_PWM_TRI    = 0;
    localparam int unsigned         PWM_PIN_LO     = 5;
    localparam logic [7:0]          LATCH_RST      = 8'h00;
    localparam logic [7:0]          DIR_RST        = 8'hFF;
    localparam logic [7:0]          NEIGH_RST      = 8'h00;
    localparam logic [7:0]          MUX_RST        = 8'h00;
    localparam logic [1:0]          HTRANS_NONSEQ  = 2'h2;
    localparam logic [2:0]          HSIZE_WORD     = 3'h2;

    // streaming parallel port side: drive data, enable and ownership of the pins
    typedef struct packed {
        logic       enable;
        logic [7:0] out_data;
        logic [7:0] out_en;
    } biop_stream_t;

    // enhanced pwm side: channel b,c,d levels, multi-output mode, shutdown
    typedef struct packed {
        logic       multi_out;
        logic [2:0] chan;
        logic       shutdown;
    } biop_pwm_t;
endpackage : biop_pkg
`default_nettype wire
